// ### src/mbc_pkg.sv
package mbc_pkg;
	// ----------------------------------------
	// register offsets (low address byte)
	// ----------------------------------------
	localparam logic [7:0] X_START_ADDRESS_OFS = 8'he0;
	localparam logic [7:0] X_END_ADDRESS_OFS = 8'he1;
	localparam logic [7:0] X_RELOAD_ADDRESS_OFS = 8'he2;
	localparam logic [7:0] PAIR_COUNT_OFS = 8'he3;
	localparam logic [7:0] Y_START_ADDRESS_OFS = 8'he4;
	localparam logic [7:0] Y_END_ADDRESS_OFS = 8'he5;
	localparam logic [7:0] Y_RELOAD_ADDRESS_OFS = 8'he6;
	localparam logic [7:0] MAC_CONTROL_OFS = 8'he7;
	localparam logic [7:0] ACC_BYTE0_OFS = 8'he8;
	localparam logic [7:0] ACC_BYTE1_OFS = 8'he9;
	localparam logic [7:0] ACC_BYTE2_OFS = 8'hea;
	localparam logic [7:0] ACC_BYTE3_OFS = 8'heb;
	localparam logic [7:0] ACC_TOP_BYTE_OFS = 8'hec;
	localparam logic [7:0] MAC_STATUS_OFS = 8'hed;
	// ----------------------------------------
	// fields and values
	// ----------------------------------------
	localparam int CTL_IE_BIT = 7;
	localparam logic [7:0] STATUS_SWAP_CMD = 8'h80;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [5:0] RAM_WIN_HI = 6'h37;
	localparam int STAT_STAGE_LSB = 0;
	localparam int STAT_COMP_LSB = 4;
	localparam int ACC_W = 40;
	localparam int OPER_W = 16;
	typedef enum logic [1:0] {ST_EMPTY, ST_READY, ST_BUSY, ST_DONE} mbc_bank_t;
	typedef struct packed {
		logic [7:0] xs, xe, xr, len, ys, ye, yr, ctl;
		logic [ACC_W-1:0] acc;
	} mbc_setup_t;
endpackage

// ### src/mbc_ram.sv
// dual-port operand ram: host byte port rw, mac word port read only
module mbc_ram
(
	input wire logic ref_clk_i,
	input wire logic host_we_i,
	input wire logic [9:0] host_addr_i,
	input wire logic [7:0] host_wdata_i,
	output logic [7:0] host_rdata_o,
	input wire logic [7:0] x_idx_i,
	input wire logic [7:0] y_idx_i,
	output logic [15:0] x_word_o,
	output logic [15:0] y_word_o
);
	// even byte is low half, odd byte high half
	logic [7:0] lo_mem_ff [0:511];
	logic [7:0] hi_mem_ff [0:511];

	always_ff @(posedge ref_clk_i)
	begin
		if (host_we_i && !host_addr_i[0])
			lo_mem_ff[host_addr_i[9:1]] <= host_wdata_i;
		if (host_we_i && host_addr_i[0])
			hi_mem_ff[host_addr_i[9:1]] <= host_wdata_i;
	end

	always_ff @(posedge ref_clk_i)
	begin
		host_rdata_o <= host_addr_i[0] ? hi_mem_ff[host_addr_i[9:1]]
			: lo_mem_ff[host_addr_i[9:1]];
		x_word_o <= {hi_mem_ff[{1'b0, x_idx_i}], lo_mem_ff[{1'b0, x_idx_i}]};
		y_word_o <= {hi_mem_ff[{1'b1, y_idx_i}], lo_mem_ff[{1'b1, y_idx_i}]};
	end
endmodule // mbc_ram

// ### src/mbc_top.sv
// Function
// - block write ending on control or accumulator byte makes staging ready
// - staging ready and compute empty or done: swap, compute in progress
// - finished sequence turns compute in progress into done
// - status write of 80h with staging empty, compute done swaps banks
// - both banks empty means no result available
// - upper address byte marks end of block input transfer
// - last result byte read empties staging, or swaps if another pending
// - ram is 1KB of bytes, seen as two 256x16 arrays
// - ram dual ported: host read write, mac read only
// - host ram window fixed at dc00h to dfffh; upper-address byte is not used
// - x array at dc00h-ddffh, y array at de00h-dfffh
// - even byte is operand low half, odd byte high half
// - first operands fetched at x and y start indices
// - indices increment, reload after end index used
// - accumulate until operation count equals pair count
// - host registers reach staging bank only
// - x start and end are 8-bit rw, reset zero
// - any control write clears 40-bit accumulator
// - interrupt on done when enable set for that calculation
// - read of top accumulator byte empties done staging bank unless compute bank is done
module mbc_top
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [15:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic mem_wr_i,
	input wire logic mem_rd_i,
	input wire logic [15:0] mem_addr_i,
	input wire logic [7:0] mem_wdata_i,
	input wire logic [7:0] ram_addr_upper_i,
	output logic [7:0] io_rdata_o,
	output logic [7:0] mem_rdata_o,
	output logic mem_hit_o,
	output logic irq_o
);
	import mbc_pkg::*;

	// ----------------------------------------
	// host decode
	// ----------------------------------------
	logic ram_hit, ram_we, io_last, stat_wr, reg_wr, acc_rd, acc_rd_end;
	logic [7:0] ram_rdata;
	logic [15:0] x_word, y_word;
	mbc_setup_t stage_ff, comp_ff;
	mbc_bank_t stage_st_ff, comp_st_ff;
	logic [7:0] x_idx_ff, y_idx_ff, cnt_ff;
	logic run_ff, fetch_ff, comp_ie_ff, ram_sel_ff;
	logic [7:0] io_rdata_ff;

	// mem address bits 15:10 must equal RAM_WIN_HI; the upper-address register is not used
	assign ram_hit = (mem_addr_i[15:10] == RAM_WIN_HI);
	assign ram_we = mem_wr_i && ram_hit;
	// block transfers count io_addr[15:8] down; zero marks the final byte
	assign io_last = (io_addr_i[15:8] == 8'h00);
	assign stat_wr = io_wr_i && io_addr_i[7:0] == MAC_STATUS_OFS;
	assign reg_wr = io_wr_i && io_addr_i[7:0] >= X_START_ADDRESS_OFS
		&& io_addr_i[7:0] <= ACC_TOP_BYTE_OFS;
	assign acc_rd = io_rd_i && io_addr_i[7:0] >= ACC_BYTE0_OFS
		&& io_addr_i[7:0] <= ACC_TOP_BYTE_OFS;
	assign acc_rd_end = acc_rd && (io_last || io_addr_i[7:0] == ACC_TOP_BYTE_OFS);
	// a block write that ends on control or an accumulator byte arms the bank
	logic blk_out_end, stage_wr_drop;
	assign blk_out_end = reg_wr && io_last && (io_addr_i[7:0] == MAC_CONTROL_OFS
		|| io_addr_i[7:0] >= ACC_BYTE0_OFS);
	// any other register write throws away an unread result
	assign stage_wr_drop = reg_wr && stage_st_ff == ST_DONE;

	// ----------------------------------------
	// operand ram
	// ----------------------------------------
	mbc_ram u_ram
	(
		.ref_clk_i(ref_clk_i),
		.host_we_i(ram_we),
		.host_addr_i(mem_addr_i[9:0]),
		.host_wdata_i(mem_wdata_i),
		.host_rdata_o(ram_rdata),
		.x_idx_i(x_idx_ff),
		.y_idx_i(y_idx_ff),
		.x_word_o(x_word),
		.y_word_o(y_word)
	);

	// ----------------------------------------
	// bank status machine
	// ----------------------------------------
	logic do_swap_start, do_swap_fetch, do_swap_back, done_evt, stage_done_read;
	logic last_op, mac_step;
	assign mac_step = run_ff && !fetch_ff;
	// full signed product, sign-extended to the accumulator width by the cast
	logic signed [2*OPER_W-1:0] mac_prod;
	assign mac_prod = $signed(x_word) * $signed(y_word);
	assign last_op = mac_step && (cnt_ff == comp_ff.len);
	assign done_evt = run_ff && (comp_ff.len == 8'h00 || last_op);
	// a finishing calculation reaches done before it can be swapped out
	assign do_swap_start = stage_st_ff == ST_READY
		&& (comp_st_ff == ST_EMPTY || comp_st_ff == ST_DONE) && !done_evt;
	assign do_swap_fetch = stat_wr && io_wdata_i == STATUS_SWAP_CMD
		&& stage_st_ff == ST_EMPTY && comp_st_ff == ST_DONE;
	assign stage_done_read = stage_st_ff == ST_DONE && acc_rd_end;
	// a pending result takes the place of the one just read
	assign do_swap_back = stage_done_read && comp_st_ff == ST_DONE;

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			stage_st_ff <= ST_EMPTY;
			comp_st_ff <= ST_EMPTY;
		end
		else if (do_swap_start)
		begin
			stage_st_ff <= comp_st_ff; // done result comes back to host side
			comp_st_ff <= ST_BUSY;
		end
		else if (do_swap_fetch)
		begin
			stage_st_ff <= ST_DONE;
			comp_st_ff <= ST_EMPTY;
		end
		else
		begin
			if (done_evt)
				comp_st_ff <= ST_DONE;
			if (blk_out_end)
				stage_st_ff <= ST_READY;
			else if (stage_done_read)
			begin
				// a calculation finishing now stays in the compute bank
				if (do_swap_back)
				begin
					stage_st_ff <= ST_DONE;
					comp_st_ff <= ST_EMPTY;
				end
				else
					stage_st_ff <= ST_EMPTY;
			end
			else if (stage_wr_drop)
				stage_st_ff <= ST_EMPTY;
		end
	end

	// ----------------------------------------
	// staging and compute register banks
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			stage_ff <= '0;
			comp_ff <= '0;
		end
		else if (do_swap_start || do_swap_fetch || do_swap_back)
		begin
			// setup and accumulator travel together with the status
			stage_ff <= comp_ff;
			comp_ff <= stage_ff;
		end
		else
		begin
			if (mac_step)
				comp_ff.acc <= comp_ff.acc + ACC_W'(mac_prod);
			if (io_wr_i)
			begin
				// host writes only touch staging bank
				case (io_addr_i[7:0])
					X_START_ADDRESS_OFS: stage_ff.xs <= io_wdata_i;
					X_END_ADDRESS_OFS: stage_ff.xe <= io_wdata_i;
					X_RELOAD_ADDRESS_OFS: stage_ff.xr <= io_wdata_i;
					PAIR_COUNT_OFS: stage_ff.len <= io_wdata_i;
					Y_START_ADDRESS_OFS: stage_ff.ys <= io_wdata_i;
					Y_END_ADDRESS_OFS: stage_ff.ye <= io_wdata_i;
					Y_RELOAD_ADDRESS_OFS: stage_ff.yr <= io_wdata_i;
					MAC_CONTROL_OFS:
					begin
						stage_ff.ctl <= io_wdata_i;
						stage_ff.acc <= '0;
					end
					ACC_BYTE0_OFS: stage_ff.acc[7:0] <= io_wdata_i;
					ACC_BYTE1_OFS: stage_ff.acc[15:8] <= io_wdata_i;
					ACC_BYTE2_OFS: stage_ff.acc[23:16] <= io_wdata_i;
					ACC_BYTE3_OFS: stage_ff.acc[31:24] <= io_wdata_i;
					ACC_TOP_BYTE_OFS: stage_ff.acc[39:32] <= io_wdata_i;
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// index sequencer
	// ----------------------------------------
	logic [7:0] nxt_x_idx, nxt_y_idx;
	// circular step: the end index hands over to the reload index
	assign nxt_x_idx = (x_idx_ff == comp_ff.xe) ? comp_ff.xr : x_idx_ff + 8'h01;
	assign nxt_y_idx = (y_idx_ff == comp_ff.ye) ? comp_ff.yr : y_idx_ff + 8'h01;
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			run_ff <= 1'b0;
			fetch_ff <= 1'b0;
			x_idx_ff <= REG_RESET;
			y_idx_ff <= REG_RESET;
			cnt_ff <= REG_RESET;
			comp_ie_ff <= 1'b0;
		end
		else if (do_swap_start)
		begin
			run_ff <= 1'b1;
			fetch_ff <= 1'b1; // one cycle for ram read latency
			x_idx_ff <= stage_ff.xs;
			y_idx_ff <= stage_ff.ys;
			cnt_ff <= 8'h01;
			comp_ie_ff <= stage_ff.ctl[CTL_IE_BIT];
		end
		else if (done_evt)
		begin
			// a zero-length run ends while its fetch is still pending
			run_ff <= 1'b0;
			fetch_ff <= 1'b0;
		end
		else if (run_ff)
		begin
			fetch_ff <= 1'b0;
			if (mac_step)
				cnt_ff <= cnt_ff + 8'h01;
			// words for cycle n are read from indices set in cycle n-1
			if (fetch_ff || !last_op)
			begin
				x_idx_ff <= nxt_x_idx;
				y_idx_ff <= nxt_y_idx;
			end
		end
	end

	// ----------------------------------------
	// read data, ram hit
	// ----------------------------------------
	logic [7:0] stat_val;
	always_comb
	begin
		stat_val = 8'h00;
		stat_val[STAT_STAGE_LSB +: 2] = stage_st_ff;
		stat_val[STAT_COMP_LSB +: 2] = comp_st_ff;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			io_rdata_ff <= REG_RESET;
		else
		begin
			case (io_addr_i[7:0])
				X_START_ADDRESS_OFS: io_rdata_ff <= stage_ff.xs;
				X_END_ADDRESS_OFS: io_rdata_ff <= stage_ff.xe;
				X_RELOAD_ADDRESS_OFS: io_rdata_ff <= stage_ff.xr;
				PAIR_COUNT_OFS: io_rdata_ff <= stage_ff.len;
				Y_START_ADDRESS_OFS: io_rdata_ff <= stage_ff.ys;
				Y_END_ADDRESS_OFS: io_rdata_ff <= stage_ff.ye;
				Y_RELOAD_ADDRESS_OFS: io_rdata_ff <= stage_ff.yr;
				MAC_CONTROL_OFS: io_rdata_ff <= stage_ff.ctl;
				ACC_BYTE0_OFS: io_rdata_ff <= stage_ff.acc[7:0];
				ACC_BYTE1_OFS: io_rdata_ff <= stage_ff.acc[15:8];
				ACC_BYTE2_OFS: io_rdata_ff <= stage_ff.acc[23:16];
				ACC_BYTE3_OFS: io_rdata_ff <= stage_ff.acc[31:24];
				ACC_TOP_BYTE_OFS: io_rdata_ff <= stage_ff.acc[39:32];
				MAC_STATUS_OFS: io_rdata_ff <= stat_val;
				default: io_rdata_ff <= 8'h00;
			endcase
		end
	end
	assign io_rdata_o = io_rdata_ff;
	assign mem_rdata_o = ram_rdata;

	// a read matching the ram window on mem address bits 15:10 is registered here; mem_hit_o follows one cycle later, writes never set it
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			ram_sel_ff <= 1'b0;
		else
			ram_sel_ff <= mem_rd_i && ram_hit;
	end
	assign mem_hit_o = ram_sel_ff;

	// ----------------------------------------
	// done interrupt
	// ----------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			// level while an enabled result waits in the compute bank
			irq_o <= comp_ie_ff && (done_evt || comp_st_ff == ST_DONE);
	end
endmodule // mbc_top

// ### dv/mbc_chk.sv
module mbc_chk
	import mbc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [15:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic mem_wr_i,
	input wire logic mem_rd_i,
	input wire logic [15:0] mem_addr_i,
	input wire logic [7:0] mem_wdata_i,
	input wire logic [7:0] io_rdata_o,
	input wire logic [7:0] mem_rdata_o,
	input wire logic mem_hit_o,
	input wire logic irq_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	logic win;
	assign win = mem_addr_i[15:10] == RAM_WIN_HI;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_rw(logic [7:0] o);
		io_wr_i && io_addr_i[7:0] == o ##1 io_rd_i && io_addr_i[7:0] == o
		|=> io_rdata_o == $past(io_wdata_i, 2);
	endproperty
	hit_in_a: assert property (mem_rd_i && win |=> mem_hit_o)
		else $error("ram read not flagged");
	hit_out_a: assert property (!(mem_rd_i && win) |=> !mem_hit_o)
		else $error("ram hit without ram read");
	ram_rw_a: assert property (mem_wr_i && win ##1 mem_rd_i && $stable(mem_addr_i)
		|=> mem_rdata_o == $past(mem_wdata_i, 2)) else $error("ram byte lost");
	x_start_a: assert property (p_rw(X_START_ADDRESS_OFS))
		else $error("x start read back wrong");
	x_end_a: assert property (p_rw(X_END_ADDRESS_OFS))
		else $error("x end read back wrong");
	y_start_a: assert property (p_rw(Y_START_ADDRESS_OFS))
		else $error("y start read back wrong");
	unmapped_a: assert property (io_rd_i && io_addr_i[7:0] < X_START_ADDRESS_OFS
		|=> io_rdata_o == 8'h00) else $error("unmapped read not zero");
	acc_clr_a: assert property (io_wr_i && io_addr_i == {8'h01, MAC_CONTROL_OFS} ##1
		io_rd_i && io_addr_i[7:0] == ACC_BYTE0_OFS |=> io_rdata_o == 8'h00)
		else $error("accumulator not cleared");
	comp_field_a: assert property (io_rd_i && io_addr_i[7:0] == MAC_STATUS_OFS
		|=> io_rdata_o[5:4] != ST_READY) else $error("compute bank shows ready");
	cover property (mem_rd_i && win ##1 mem_hit_o);
	cover property ($rose(irq_o));
	cover property (io_wr_i && io_addr_i[7:0] == MAC_STATUS_OFS && io_wdata_i == STATUS_SWAP_CMD);
endmodule // mbc_chk

bind mbc_top mbc_chk i_chk (.*);

// ### dv/mbc_host.sv
module mbc_host
(
	input wire logic ref_clk_i,
	output logic io_wr_o,
	output logic io_rd_o,
	output logic [15:0] io_addr_o,
	output logic [7:0] io_wdata_o,
	output logic mem_wr_o,
	output logic mem_rd_o,
	output logic [15:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	output logic [7:0] ram_addr_upper_o
);
	timeunit 1ns;
	timeprecision 100ps;
	assign ram_addr_upper_o = 8'h00;
	initial
	begin
		{io_addr_o, io_wdata_o, mem_addr_o, mem_wdata_o} = '0;
		{io_wr_o, io_rd_o, mem_wr_o, mem_rd_o} = 4'h0;
	end
	// ----------------------------------------
	// one byte per cycle, callers start on a rising edge
	// ----------------------------------------
	task automatic io_acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		#1;
		{mem_wr_o, mem_rd_o} = 2'b00;
		{io_wr_o, io_rd_o} = {w, !w};
		io_addr_o = a;
		io_wdata_o = w ? d : ~io_wdata_o;
		@(posedge ref_clk_i);
	endtask
	task automatic mem_acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		#1;
		{io_wr_o, io_rd_o} = 2'b00;
		{mem_wr_o, mem_rd_o} = {w, !w};
		mem_addr_o = a;
		mem_wdata_o = w ? d : ~mem_wdata_o;
		@(posedge ref_clk_i);
	endtask
	// released lines flip so a stale value never looks valid
	task automatic idle();
		#1;
		{io_wr_o, io_rd_o, mem_wr_o, mem_rd_o} = 4'h0;
		{io_addr_o, io_wdata_o, mem_addr_o, mem_wdata_o} = ~{io_addr_o, io_wdata_o, mem_addr_o, mem_wdata_o};
		@(posedge ref_clk_i);
	endtask
endmodule // mbc_host

// ### dv/mbc_top_tb.sv
module mbc_top_tb
	import mbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk_i, rst_i, io_wr, io_rd, mem_wr, mem_rd, hit, irq;
	logic [15:0] io_a, mem_a;
	logic [7:0] io_wd, mem_wd, up, io_q, mem_q, v;
	logic io_p = 1'b0, mem_p = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] ofs[3] = '{X_START_ADDRESS_OFS, X_END_ADDRESS_OFS, Y_START_ADDRESS_OFS};
	logic [7:0] cfg[8] = '{8'h00, 8'h01, 8'h00, 8'h03, 8'h01, 8'h02, 8'h00, 8'h80};
	logic signed [15:0] x[4], y[4];
	logic signed [39:0] acc;
	int fails = 0, n_checks = 0, k;
	integer seed = 32'h1d8ebfaf;
	mbc_host i_host (.ref_clk_i(ref_clk_i), .io_wr_o(io_wr), .io_rd_o(io_rd), .io_addr_o(io_a),
		.io_wdata_o(io_wd), .mem_wr_o(mem_wr), .mem_rd_o(mem_rd), .mem_addr_o(mem_a),
		.mem_wdata_o(mem_wd), .ram_addr_upper_o(up));
	mbc_top i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .io_wr_i(io_wr), .io_rd_i(io_rd),
		.io_addr_i(io_a), .io_wdata_i(io_wd), .mem_wr_i(mem_wr), .mem_rd_i(mem_rd),
		.mem_addr_i(mem_a), .mem_wdata_i(mem_wd), .ram_addr_upper_i(up), .io_rdata_o(io_q),
		.mem_rdata_o(mem_q), .mem_hit_o(hit), .irq_o(irq));
	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		i_host.io_acc(1'b1, a, d);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.io_acc(1'b0, a, 8'h00);
	endtask
	task automatic mrd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.mem_acc(1'b0, a, 8'h00);
	endtask
	task automatic give_verdict();
		// a read whose answer never arrived counts against the run
		if (exp_q.size() != 0)
			fails++;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------
	// monitor: answer lands one edge after the strobe
	// ----------------------------------------
	always @(posedge ref_clk_i)
	begin
		io_p <= io_rd;
		mem_p <= mem_rd;
	end
	always @(negedge ref_clk_i)
		if ((io_p || mem_p) && exp_q.size() > 0)
			check(io_p ? io_q : mem_q, exp_q.pop_front());
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		rst_i = 1'b1;
		repeat (6) @(posedge ref_clk_i);
		#1 rst_i = 1'b0;
		@(posedge ref_clk_i);
		rd(16'h00e0, REG_RESET);
		rd(16'h00e1, REG_RESET);
		rd(16'h00ed, 8'h00);
		rd(16'h0010, 8'h00);
		$display("reset test done");
		for (int j = 0; j < 9; j++)
		begin
			v = (j < 3) ? 8'hff : 8'($random(seed));
			wr({8'h01, ofs[j % 3]}, v);
			rd({8'h01, ofs[j % 3]}, v);
		end
		wr(16'h01e8, 8'h5a);
		wr(16'h01e7, 8'h00);
		rd(16'h01e8, 8'h00);
		$display("register test done");
		for (int i = 0; i < 4; i++)
		begin
			x[i] = 16'($random(seed));
			y[i] = 16'($random(seed));
			i_host.mem_acc(1'b1, 16'hdc00 + 16'(2 * i), x[i][7:0]);
			i_host.mem_acc(1'b1, 16'hdc01 + 16'(2 * i), x[i][15:8]);
			i_host.mem_acc(1'b1, 16'hde00 + 16'(2 * i), y[i][7:0]);
			i_host.mem_acc(1'b1, 16'hde01 + 16'(2 * i), y[i][15:8]);
		end
		mrd(16'hdc01, x[0][15:8]);
		mrd(16'hde06, y[3][7:0]);
		i_host.mem_acc(1'b0, 16'hd000, 8'h00);
		$display("ram test done");
		for (int i = 0; i < 8; i++)
			wr({8'(7 - i), X_START_ADDRESS_OFS + 8'(i)}, cfg[i]);
		// drop the strobe so the final control write is not repeated
		i_host.idle();
		for (k = 0; k < 200 && irq !== 1'b1; k++)
			@(posedge ref_clk_i);
		check({7'h00, irq}, 8'h01);
		if (irq === 1'b1)
		begin
			rd(16'h00ed, {2'b00, ST_DONE, 2'b00, ST_EMPTY});
			wr(16'h00ed, STATUS_SWAP_CMD);
			rd(16'h00ed, {2'b00, ST_EMPTY, 2'b00, ST_DONE});
			acc = x[0] * y[1] + x[1] * y[2] + x[0] * y[0];
			for (int i = 0; i < 5; i++)
				rd({8'(4 - i), ACC_BYTE0_OFS + 8'(i)}, acc[8 * i +: 8]);
			rd(16'h00ed, 8'h00);
			i_host.idle();
			$display("calculation test done");
		end
		give_verdict();
	end
endmodule // mbc_top_tb
